// ==== ssb_params.svh ====
// constants for the burst sram control block
`ifndef SSB_PARAMS_SVH
`define SSB_PARAMS_SVH
`define SSB_ADDR_W       20
`define SSB_LANES        2
`define SSB_LANE_W       9
`define SSB_WORD_W       18
`define SSB_DEPTH        1048576
`define SSB_SLEEP_CYC    2
`define SSB_WB_STATUS    8'h00
`define SSB_WB_WCOUNT    8'h04
`define SSB_WB_CTRL      8'h08
`define SSB_CTRL_CLR_BIT 0
`define SSB_WCOUNT_RST   16'h0000
`define SSB_WB_DAT_RST   32'h00000000
`endif

// ==== ssb_pkg.sv ====
// types shared by the burst sram control modules
package ssb_pkg;
`include "ssb_params.svh"

   // gray order along desel, read, write, sleep
   typedef enum logic [1:0] {
      SSB_DESEL = 2'h0,
      SSB_READ  = 2'h1,
      SSB_WRITE = 2'h3,
      SSB_SLEEP = 2'h2
   } ssb_cycle_t;

   typedef struct packed {
      ssb_cycle_t        cycle;
      logic              drive;
      logic [17:0]       addr_hi;
      logic              sleep_s1;
      logic              sleep_s2;
      logic              mode_s1;
      logic              mode_s2;
      logic [15:0]       wcount;
      logic              wb_ack;
      logic [31:0]       wb_dat;
   } ssb_ctl_t;

   typedef struct packed {
      logic [1:0]        first;
      logic [1:0]        idx;
   } ssb_cnt_t;
endpackage

// ==== ssb_core_if.sv ====
// links between the control core, burst counter and array
`timescale 1ns/10ps
interface ssb_core_if;
   logic        cnt_load;
   logic        cnt_adv;
   logic        cnt_inter;
   logic [1:0]  cnt_start;
   logic [1:0]  cnt_value;
   logic [1:0]  cnt_peek;
   logic        mem_we;
   logic [1:0]  mem_lane;
   logic [19:0] mem_waddr;
   logic [17:0] mem_wdata;
   logic [19:0] mem_raddr;
   logic [17:0] mem_rdata;

   modport ctl (output cnt_load, cnt_adv, cnt_inter, cnt_start, mem_we, mem_lane,
                mem_waddr, mem_wdata, mem_raddr,
                input cnt_value, cnt_peek, mem_rdata);
   modport cnt (input cnt_load, cnt_adv, cnt_inter, cnt_start,
                output cnt_value, cnt_peek);
   modport mem (input mem_we, mem_lane, mem_waddr, mem_wdata, mem_raddr,
                output mem_rdata);
endinterface

// ==== ssb_burst_counter.sv ====
// two-bit wraparound burst address counter
`timescale 1ns/10ps
module ssb_burst_counter (
   input  wire logic clk,
   input  wire logic reset,
   ssb_core_if.cnt   core
);
   ssb_pkg::ssb_cnt_t cnt_reg;
   ssb_pkg::ssb_cnt_t cnt_next;

   // address is the first address combined with the step index
   function automatic logic [1:0] ssb_order(input logic inter, input logic [1:0] f, input logic [1:0] k);
      ssb_order = inter ? (f ^ k) : 2'(f + k);
   endfunction

   // load on a strobe, step on advance, else hold
   always_comb begin
      cnt_next = cnt_reg;
      if (core.cnt_load) begin
         cnt_next.first = core.cnt_start;
         cnt_next.idx   = 2'h0;
      end else if (core.cnt_adv) begin
         cnt_next.idx = 2'(cnt_reg.idx + 2'h1);
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   assign core.cnt_value = ssb_order(core.cnt_inter, cnt_reg.first, cnt_reg.idx);
   assign core.cnt_peek  = ssb_order(core.cnt_inter, cnt_next.first, cnt_next.idx);

   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   chk_burst_second_step: assert property (
      core.cnt_load ##1 (core.cnt_adv && !core.cnt_load && $stable(core.cnt_inter)) |=>
      core.cnt_value == (core.cnt_inter ? ($past(core.cnt_start, 2) ^ 2'h1) : 2'($past(core.cnt_start, 2) + 2'h1)))
      else $error("burst step address wrong");
   chk_burst_hold: assert property (
      (!core.cnt_load && !core.cnt_adv) ##1 $stable(core.cnt_inter) |-> $stable(core.cnt_value))
      else $error("burst address moved without advance");
endmodule

// ==== ssb_array.sv ====
// storage array with per-lane writes, one lane per byte and parity bit
`timescale 1ns/10ps
`include "ssb_params.svh"
module ssb_array (
   input  wire logic clk,
   ssb_core_if.mem   core
);
   // lane i holds byte i and its parity bit; lane 1 is the upper byte
   for (genvar i = 0; i < `SSB_LANES; i++) begin : g_lane
      logic [8:0] lane_mem [0:`SSB_DEPTH-1];

      // only selected lanes change; nothing resets the contents
      always_ff @(posedge clk) begin
         if (core.mem_we && core.mem_lane[i]) begin
            lane_mem[core.mem_waddr] <= core.mem_wdata[9*i +: 9];
         end
      end
      assign core.mem_rdata[9*i +: 9] = lane_mem[core.mem_raddr];
   end
endmodule

// ==== ssb_sleep_control.sv ====
// control core of a flow-through burst sram with sleep mode
`timescale 1ns/10ps
`include "ssb_params.svh"
// Operation
// - interleaved burst xors low bits with step
// - linear burst adds step, wraps in four
// - sleep request is asynchronous, high sleeps
// - two clocks to enter and leave sleep
// - contents kept while asleep
// - access pending at sleep may be dropped
// - write when global or lane write active
// - data pins follow cycle type and enable
// - output enable acts unregistered
// - processor strobe starts a read when selected
// - writes only after processor strobe or controller
// - write cycles mask the output enable
// - reads drive on enable low, else release
// - each lane select writes its byte, parity
// - upper lane select owns upper byte
// - mode strap low linear, high interleaved
// - burst counter loads from two low address
module ssb_sleep_control (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        chip_select_primary_n,
   input  wire logic        depth_select_high,
   input  wire logic        depth_select_low_n,
   input  wire logic        processor_addr_strobe_n,
   input  wire logic        controller_addr_strobe_n,
   input  wire logic        burst_advance_n,
   input  wire logic        global_write_n,
   input  wire logic        byte_write_enable_n,
   input  wire logic [1:0]  byte_lane_select_n,
   input  wire logic [19:0] addr,
   input  wire logic        output_enable_n,
   input  wire logic        sleep_request,
   input  wire logic        burst_order_mode,
   input  wire logic [15:0] data_io_in,
   output logic [15:0]      data_io_out,
   output logic             data_io_oe_n,
   input  wire logic [1:0]  parity_io_in,
   output logic [1:0]       parity_io_out,
   output logic             parity_io_oe_n,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o
);
   ssb_pkg::ssb_ctl_t ctl_reg;
   ssb_pkg::ssb_ctl_t ctl_next;

   ssb_core_if core ();

   logic        asleep;
   logic        selected;
   logic        proc_start;
   logic        ctrl_start;
   logic        write_ind;
   logic        cont_ok;
   logic        do_load;
   logic        do_adv;
   logic        do_write;
   logic [1:0]  lanes;
   logic [17:0] wdata;
   logic        wb_req;
   logic        wb_wr;
   logic        wcount_clr;

   ssb_burst_counter u_counter (
      .clk   (clk),
      .reset (reset),
      .core  (core)
   );

   ssb_array u_array (
      .clk  (clk),
      .core (core)
   );

   // the second synchroniser stage is the sleep state itself,
   // so entry and exit each take exactly two clock edges
   assign asleep = ctl_reg.sleep_s2;

   // all three selects asserted
   assign selected = !chip_select_primary_n && depth_select_high && !depth_select_low_n;

   // processor strobe counts only with primary select low
   assign proc_start = !processor_addr_strobe_n && !chip_select_primary_n;

   // controller strobe is taken only when processor strobe is not
   assign ctrl_start = !controller_addr_strobe_n && !proc_start;

   // internal write indication
   assign write_ind = !global_write_n || (!byte_write_enable_n && !(&byte_lane_select_n));

   // a burst may continue only after a selected strobe
   assign cont_ok = (ctl_reg.cycle == ssb_pkg::SSB_READ) || (ctl_reg.cycle == ssb_pkg::SSB_WRITE);

   // lanes to write: global write takes every lane
   assign lanes = !global_write_n ? 2'h3 : ~byte_lane_select_n;

   // lane i gets its byte with its parity bit on top
   assign wdata = {parity_io_in[1], data_io_in[15:8], parity_io_in[0], data_io_in[7:0]};

   // register bus: ack follows one cycle after the request
   assign wb_req = wb_cyc_i && wb_stb_i;
   assign wb_wr  = wb_req && wb_we_i && ctl_reg.wb_ack;
   assign wcount_clr = wb_wr && (wb_adr_i == `SSB_WB_CTRL) && wb_sel_i[0] && wb_dat_i[`SSB_CTRL_CLR_BIT];

   // cycle decode; sleep blocks every strobe and every write
   always_comb begin
      do_load  = 1'b0;
      do_adv   = 1'b0;
      do_write = 1'b0;
      ctl_next = ctl_reg;
      ctl_next.sleep_s1 = sleep_request;
      ctl_next.sleep_s2 = ctl_reg.sleep_s1;
      ctl_next.mode_s1  = burst_order_mode;
      ctl_next.mode_s2  = ctl_reg.mode_s1;
      if (asleep) begin
         // a pending access is simply dropped; the controller
         // was to deselect first and must not trust it
         ctl_next.cycle = ssb_pkg::SSB_SLEEP;
      end else if (proc_start || ctrl_start) begin
         if (!selected) begin
            ctl_next.cycle = ssb_pkg::SSB_DESEL;
         end else if (proc_start) begin
            // write inputs are ignored on a processor strobe
            do_load = 1'b1;
            ctl_next.cycle = ssb_pkg::SSB_READ;
         end else begin
            do_load  = 1'b1;
            do_write = write_ind;
            ctl_next.cycle = write_ind ? ssb_pkg::SSB_WRITE : ssb_pkg::SSB_READ;
         end
      end else if (cont_ok) begin
         do_adv   = !burst_advance_n;
         do_write = write_ind;
         ctl_next.cycle = write_ind ? ssb_pkg::SSB_WRITE : ssb_pkg::SSB_READ;
      end else begin
         ctl_next.cycle = ssb_pkg::SSB_DESEL;
      end
      if (do_load) begin
         ctl_next.addr_hi = addr[19:2];
      end
      // only a read cycle may drive; writes mask the output enable
      ctl_next.drive = (ctl_next.cycle == ssb_pkg::SSB_READ);
      // write counter: a write in the same cycle as a clear leaves a count of one
      if (wcount_clr) begin
         ctl_next.wcount = do_write ? 16'h0001 : `SSB_WCOUNT_RST;
      end else if (do_write) begin
         ctl_next.wcount = 16'(ctl_reg.wcount + 16'h0001);
      end
      ctl_next.wb_ack = wb_req && !ctl_reg.wb_ack;
      ctl_next.wb_dat = `SSB_WB_DAT_RST;
      if (wb_req && !ctl_reg.wb_ack && !wb_we_i) begin
         case (wb_adr_i)
            `SSB_WB_STATUS: begin
               ctl_next.wb_dat = {26'h0000000, ctl_reg.mode_s2, asleep, ctl_reg.cycle, core.cnt_value};
            end
            `SSB_WB_WCOUNT: begin
               ctl_next.wb_dat = {16'h0000, ctl_reg.wcount};
            end
            default: begin
               ctl_next.wb_dat = `SSB_WB_DAT_RST;
            end
         endcase
      end
   end

   // the storage array has no reset; this control state and the burst counter do
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ctl_reg.cycle    <= ssb_pkg::SSB_DESEL;
         ctl_reg.drive    <= 1'b0;
         ctl_reg.addr_hi  <= 18'h00000;
         ctl_reg.sleep_s1 <= 1'b0;
         ctl_reg.sleep_s2 <= 1'b0;
         ctl_reg.mode_s1  <= 1'b1;
         ctl_reg.mode_s2  <= 1'b1;
         ctl_reg.wcount   <= `SSB_WCOUNT_RST;
         ctl_reg.wb_ack   <= 1'b0;
         ctl_reg.wb_dat   <= `SSB_WB_DAT_RST;
      end else begin
         ctl_reg <= ctl_next;
      end
   end

   // counter and array hookup
   assign core.cnt_load  = do_load;
   assign core.cnt_adv   = do_adv;
   assign core.cnt_start = addr[1:0];
   assign core.cnt_inter = ctl_reg.mode_s2;
   assign core.mem_we    = do_write && !asleep;
   assign core.mem_lane  = lanes;
   assign core.mem_waddr = {do_load ? addr[19:2] : ctl_reg.addr_hi, core.cnt_peek};
   assign core.mem_wdata = wdata;
   assign core.mem_raddr = {ctl_reg.addr_hi, core.cnt_value};

   // flow-through read data straight from the array
   assign data_io_out   = {core.mem_rdata[16:9], core.mem_rdata[7:0]};
   assign parity_io_out = {core.mem_rdata[17], core.mem_rdata[8]};

   // output enable is deliberately not registered so the pins
   // turn round as soon as the controller moves it
   assign data_io_oe_n   = !(ctl_reg.drive && !output_enable_n && !asleep);
   assign parity_io_oe_n = !(ctl_reg.drive && !output_enable_n && !asleep);

   assign wb_dat_o = ctl_reg.wb_dat;
   assign wb_ack_o = ctl_reg.wb_ack;

   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   chk_sleep_entry_two: assert property (sleep_request [*2] |=> asleep)
      else $error("sleep not entered two clocks after request");
   chk_sleep_exit_two: assert property (!sleep_request [*2] |=> !asleep)
      else $error("sleep not left two clocks after release");
   chk_sleep_pins_off: assert property (asleep |-> data_io_oe_n && parity_io_oe_n)
      else $error("pins driven while asleep");
   chk_sleep_no_write: assert property (asleep |-> !core.mem_we)
      else $error("array written while asleep");
   chk_proc_strobe_read: assert property (
      (!asleep && proc_start && selected) |-> !core.mem_we ##1 (ctl_reg.cycle == ssb_pkg::SSB_READ))
      else $error("processor strobe did not start a read");
   chk_write_needs_ind: assert property (core.mem_we |-> write_ind && !proc_start)
      else $error("write without write indication");
   chk_write_masks_oe: assert property (ctl_reg.cycle == ssb_pkg::SSB_WRITE |-> data_io_oe_n)
      else $error("data driven in a write cycle");
   chk_read_drives: assert property (
      (!asleep && ctl_reg.cycle == ssb_pkg::SSB_READ && !output_enable_n) |-> !data_io_oe_n)
      else $error("read cycle with enable low not driving");
   chk_deselect_strobe: assert property (
      (!asleep && (proc_start || ctrl_start) && !selected)
      |=> ctl_reg.cycle == ssb_pkg::SSB_DESEL ##0 data_io_oe_n)
      else $error("deselected strobe still selected the device");
   chk_lane_map: assert property (
      (core.mem_we && global_write_n) |-> core.mem_lane == ~byte_lane_select_n)
      else $error("lane write mask wrong");
endmodule

// ==== ssb_ctrl_model.sv ====
// controller-side model that drives the burst sram pins
`timescale 1ns/10ps
module ssb_ctrl_model (
   input  wire logic        clk,
   input  wire logic [15:0] data_io_out,
   input  wire logic        data_io_oe_n,
   input  wire logic [1:0]  parity_io_out,
   input  wire logic        parity_io_oe_n,
   output logic             chip_select_primary_n,
   output logic             depth_select_high,
   output logic             depth_select_low_n,
   output logic             processor_addr_strobe_n,
   output logic             controller_addr_strobe_n,
   output logic             burst_advance_n,
   output logic             global_write_n,
   output logic             byte_write_enable_n,
   output logic [1:0]       byte_lane_select_n,
   output logic [19:0]      addr,
   output logic             output_enable_n,
   output logic             sleep_request,
   output logic             burst_order_mode,
   output logic [15:0]      data_io_in,
   output logic [1:0]       parity_io_in
);
   logic [17:0] dq_reg = 18'h00000;
   // shared pins: the sram wins while enabled, else our word or its inverse once released
   assign data_io_in   = !data_io_oe_n ? data_io_out : dq_reg[15:0];
   assign parity_io_in = !parity_io_oe_n ? parity_io_out : dq_reg[17:16];
   // deselected pins at time zero; strap high as if left floating
   initial begin
      {chip_select_primary_n, depth_select_high, depth_select_low_n} = 3'h5;
      {processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n} = 3'h7;
      {global_write_n, byte_write_enable_n, byte_lane_select_n, output_enable_n} = 5'h1F;
      {addr, sleep_request, burst_order_mode} = 22'h000001;
   end
   // one bus cycle; c = {selected, ps_n, cs_n, adv_n, gw_n, bwe_n, lane1_n, lane0_n}
   task automatic op(input logic [7:0] c, input logic [19:0] a, input logic [17:0] d, input logic oe);
      @(posedge clk);
      {chip_select_primary_n, depth_select_high, depth_select_low_n} <= {!c[7], c[7], !c[7]};
      {processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n} <= c[6:4];
      {global_write_n, byte_write_enable_n, byte_lane_select_n} <= c[3:0];
      addr <= a;
      output_enable_n <= oe;
      // our word while writing, else the inverse of the last one, so the sim never settles an unknown for us
      dq_reg <= (c[3] && c[2]) ? ~dq_reg : d;
   endtask
   // sleep entry and exit, sequenced as a careful controller must
   task automatic nap(input logic on);
      // a strobe with the selects off really deselects; an idle cycle would only continue
      op(8'h5F, 20'h00000, 18'h00000, 1'h1);
      @(posedge clk);
      sleep_request <= on;
      if (!on) repeat (3) op(8'h7F, 20'h00000, 18'h00000, 1'h1);
   endtask
endmodule

// ==== sync_sram_burst_sleep_control_bench.sv ====
// self-checking bench for the burst sram control block
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
   $display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module sync_sram_burst_sleep_control_bench;
   localparam logic [7:0] k_cw = 8'hD7, k_aw = 8'hE7, k_hw = 8'hF7, k_pr = 8'hBF, k_pw = 8'hB7;
   localparam logic [7:0] k_ar = 8'hEF, k_hr = 8'hFF, k_idl = 8'h7F, k_dw = 8'h57;
   logic clk = 1'h0, reset = 1'h1;
   logic chip_select_primary_n, depth_select_high, depth_select_low_n, processor_addr_strobe_n;
   logic controller_addr_strobe_n, burst_advance_n, global_write_n, byte_write_enable_n;
   logic output_enable_n, sleep_request, burst_order_mode, data_io_oe_n, parity_io_oe_n;
   logic [1:0] byte_lane_select_n, parity_io_in, parity_io_out;
   logic [15:0] data_io_in, data_io_out;
   logic [19:0] addr;
   logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, wb_ack_o;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h00000000, wb_dat_o, rd;
   int miscompares = 0, num_checks = 0;

   ssb_sleep_control dut (.clk, .reset, .chip_select_primary_n, .depth_select_high, .depth_select_low_n,
      .processor_addr_strobe_n, .controller_addr_strobe_n, .burst_advance_n, .global_write_n,
      .byte_write_enable_n, .byte_lane_select_n, .addr, .output_enable_n, .sleep_request, .burst_order_mode,
      .data_io_in, .data_io_out, .data_io_oe_n, .parity_io_in, .parity_io_out, .parity_io_oe_n,
      .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);
   ssb_ctrl_model m (.clk, .data_io_out, .data_io_oe_n, .parity_io_out, .parity_io_oe_n,
      .chip_select_primary_n, .depth_select_high, .depth_select_low_n, .processor_addr_strobe_n,
      .controller_addr_strobe_n, .burst_advance_n, .global_write_n, .byte_write_enable_n,
      .byte_lane_select_n, .addr, .output_enable_n, .sleep_request, .burst_order_mode,
      .data_io_in, .parity_io_in);

   // 50 MHz clock
   initial forever #10 clk = ~clk;

   task automatic give_verdict;
      if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // one classic wishbone cycle; the ack wait is bounded
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] wd);
      int n = 0;
      @(posedge clk);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, we, a, 4'hF, wd};
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack_o !== 1'h1 && n < 20);
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'h0;
      if (wb_ack_o !== 1'h1) begin
         miscompares++;
         give_verdict();
      end
   endtask
   task automatic idle(input int n);
      repeat (n) m.op(k_idl, 20'h00000, 18'h00000, 1'h1);
   endtask
   // read data is flow-through, so it is judged in the cycle after the loading edge
   task automatic rdchk(input logic [19:0] a, input logic [17:0] e);
      m.op(k_pr, a, 18'h00000, 1'h0);
      m.op(k_hr, a, 18'h00000, 1'h0);
      #1;
      `CHK({parity_io_out, data_io_out}, e)
      `CHK(data_io_oe_n, 1'h0)
      `CHK(parity_io_oe_n, 1'h0)
   endtask
   function automatic logic [17:0] word(input logic [1:0] k);
      return {k, 14'h1A5A, k};
   endfunction
   // burst written from wa, read back from another start, so a wrong order shows
   task automatic burst(input logic [19:0] wa, input logic [19:0] ra, input logic lin);
      logic [1:0] x;
      m.op(k_cw, wa, word(2'h0), 1'h1);
      for (int k = 1; k < 4; k++) m.op(k_aw, wa, word(k[1:0]), 1'h1);
      m.op(k_pr, ra, 18'h00000, 1'h0);
      for (int k = 0; k < 4; k++) begin
         m.op(k < 3 ? k_ar : k_hr, ra, 18'h00000, 1'h0);
         #1;
         x = lin ? ra[1:0] + k[1:0] - wa[1:0] : ra[1:0] ^ k[1:0] ^ wa[1:0];
         `CHK({parity_io_out, data_io_out}, word(x))
      end
   endtask
   task automatic s_order;
      burst(20'h00101, 20'h00102, 1'h0);
      @(posedge clk);
      m.burst_order_mode <= 1'h0;
      idle(3);
      burst(20'h00203, 20'h00201, 1'h1);
      @(posedge clk);
      m.burst_order_mode <= 1'h1;
      idle(3);
   endtask
   task automatic s_lanes;
      m.op(k_cw, 20'h00300, 18'h00000, 1'h1);
      m.op(8'hD9, 20'h00300, 18'h3FFFF, 1'h1);
      rdchk(20'h00300, 18'h2FF00);
      m.op(8'hDA, 20'h00300, 18'h3FFFF, 1'h1);
      rdchk(20'h00300, 18'h3FFFF);
      // lane enable with no lane chosen, then a processor strobe with global write low
      m.op(8'hDB, 20'h00300, 18'h00000, 1'h1);
      m.op(k_pw, 20'h00300, 18'h00000, 1'h1);
      rdchk(20'h00300, 18'h3FFFF);
      m.op(k_pr, 20'h00300, 18'h00000, 1'h1);
      m.op(k_hw, 20'h00300, 18'h15555, 1'h1);
      rdchk(20'h00300, 18'h15555);
   endtask
   task automatic s_oe;
      m.op(k_pr, 20'h00300, 18'h00000, 1'h1);
      m.op(k_hr, 20'h00300, 18'h00000, 1'h1);
      #1;
      `CHK(data_io_oe_n, 1'h1)
      @(posedge clk);
      m.output_enable_n <= 1'h0;
      #1;
      `CHK(data_io_oe_n, 1'h0)
      m.op(k_cw, 20'h00301, 18'h0A0A0, 1'h1);
      m.op(k_hw, 20'h00301, 18'h0A0A0, 1'h0);
      #1;
      `CHK(data_io_oe_n, 1'h1)
      `CHK(parity_io_oe_n, 1'h1)
      m.op(k_dw, 20'h00301, 18'h3C3C3, 1'h0);
      m.op(k_idl, 20'h00301, 18'h00000, 1'h0);
      #1;
      `CHK(data_io_oe_n, 1'h1)
      rdchk(20'h00301, 18'h0A0A0);
   endtask
   task automatic s_sleep;
      m.nap(1'h1);
      idle(3);
      wb(1'h0, 8'h00, 32'h00000000);
      `CHK(rd[4:2], 3'h6)
      m.op(k_cw, 20'h00301, 18'h3FFFF, 1'h1);
      m.op(k_pr, 20'h00301, 18'h00000, 1'h0);
      m.op(k_hr, 20'h00301, 18'h00000, 1'h0);
      #1;
      `CHK(data_io_oe_n, 1'h1)
      `CHK(parity_io_oe_n, 1'h1)
      m.nap(1'h0);
      rdchk(20'h00301, 18'h0A0A0);
      wb(1'h0, 8'h00, 32'h00000000);
      `CHK(rd[4], 1'h0)
   endtask
   task automatic s_regs;
      wb(1'h1, 8'h08, 32'h00000001);
      wb(1'h0, 8'h04, 32'h00000000);
      `CHK(rd[15:0], 16'h0000)
      m.op(k_cw, 20'h00400, 18'h00001, 1'h1);
      idle(1);
      wb(1'h0, 8'h04, 32'h00000000);
      `CHK(rd[15:0], 16'h0001)
      wb(1'h0, 8'h00, 32'h00000000);
      `CHK(rd[5], 1'h1)
      wb(1'h0, 8'h0C, 32'h00000000);
      `CHK(rd, 32'h00000000)
   endtask

   // main sequence
   initial begin
      repeat (20) @(posedge clk);
      reset <= 1'h0;
      idle(3);
      s_order();
      s_lanes();
      s_oe();
      s_sleep();
      s_regs();
      give_verdict();
   end
   // hang guard, far beyond the longest sequence
   initial begin
      #2000000;
      miscompares++;
      give_verdict();
   end
endmodule
